// File: hw/bsp_pkg.sv
// Purpose: Shared constants and types for the boost switch protection block
// Assumes: 50 MHz ref_clk_i; switching clock derived by division
// Notes: Counts are in switching clock periods unless named otherwise
package bsp_pkg;
    localparam int REF_CLK_KHZ = 50000;
    localparam int SW_FREQ_KHZ = 600;
    // Reference cycles per switching period (rounded down)
    localparam int SW_PERIOD_CYC = REF_CLK_KHZ / SW_FREQ_KHZ;
    localparam int SC_DETECT_PERIODS = 16;
    localparam int SC_RETRY_PERIODS = 512;
    localparam int SYNC_STAGES = 3;

    // Comparator and enable inputs grouped
    typedef struct packed {
        logic enable;
        logic cur_limit;
        logic overvoltage_guard;
        logic out_low;
        logic out_above_node;
        logic loop_off;
    } bsp_sense_s;

    typedef enum logic [1:0] {
        BSP_SN_IDLE,
        BSP_SN_RAMP,
        BSP_SN_CONDUCT,
        BSP_SN_CLAMP
    } bsp_snub_e;
endpackage

// File: hw/bsp_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_i
// Notes: Output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module bsp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    // Shift chain, first stage read only by second
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Accept a bit only when the last two stages agree
    wire [WIDTH-1:0] next_q;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            assign next_q[g] = (s2[g] == s3[g]) ? s3[g] : q_o[g];
        end
    endgenerate

    // Filtered output register, one process for the whole word
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q_o <= '0;
        end else begin
            q_o <= next_q;
        end
    end
endmodule
`default_nettype wire

// File: hw/bsp_ctrl.sv
// Purpose: Gate control and protection for an inductive boost LED driver
// Assumes: Comparator outputs are asynchronous and filtered by bsp_sync
// Notes: All gate outputs come straight from flip-flops
`timescale 1ns/1ps
`default_nettype none
module bsp_ctrl
    import bsp_pkg::*;
#(
    parameter int PERIOD_CYC = SW_PERIOD_CYC,
    parameter int DETECT_PERIODS = SC_DETECT_PERIODS,
    parameter int RETRY_PERIODS = SC_RETRY_PERIODS
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire bsp_sense_s sense_i,
    output logic coil_sw_on_o,
    output logic rect_sw_on_o,
    output logic snub_on_o,
    output logic short_circuit_guard_o,
    output logic sw_clk_o
);
    localparam int PW = $clog2(PERIOD_CYC + 1);
    localparam int DW = $clog2(DETECT_PERIODS + 1);
    localparam int RW = $clog2(RETRY_PERIODS + 1);

    bsp_sense_s sn;
    logic [PW-1:0] per_cnt;
    logic period_start;
    logic on_window;
    logic [DW-1:0] low_cnt;
    logic [RW-1:0] retry_cnt;
    logic retrying;
    bsp_snub_e snub_st;
    logic next_coil;
    logic next_rect;

    bsp_sync #(.WIDTH($bits(bsp_sense_s))) u_sync (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(sense_i),
        .q_o(sn)
    );

    // Switching clock divider
    assign period_start = (per_cnt == PW'(PERIOD_CYC - 1));
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            per_cnt <= '0;
        end else if (period_start) begin
            per_cnt <= '0;
        end else begin
            per_cnt <= per_cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sw_clk_o <= 1'b0;
        end else begin
            sw_clk_o <= (per_cnt < PW'(PERIOD_CYC / 2));
        end
    end

    // On-window: opened per period, closed by loop or current limit
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            on_window <= 1'b0;
        end else if (!sn.enable || retrying) begin
            on_window <= 1'b0;
        end else if (period_start) begin
            on_window <= 1'b1;
        end else if (sn.cur_limit || sn.loop_off) begin
            on_window <= 1'b0;
        end
    end

    // Low-output detect counter, counted in switching periods
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !sn.enable) begin
            low_cnt <= '0;
        end else if (!sn.out_low) begin
            low_cnt <= '0;
        end else if (period_start && !retrying &&
                     low_cnt != DW'(DETECT_PERIODS)) begin
            low_cnt <= low_cnt + 1'b1;
        end else if (retrying) begin
            low_cnt <= '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !sn.enable) begin
            short_circuit_guard_o <= 1'b0;
        end else begin
            short_circuit_guard_o <=
                (low_cnt == DW'(DETECT_PERIODS));
        end
    end

    // Retry off-interval, repeated while the fault persists
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !sn.enable) begin
            retrying <= 1'b0;
            retry_cnt <= '0;
        end else if (!retrying) begin
            if (low_cnt == DW'(DETECT_PERIODS)) begin
                retrying <= 1'b1;
                retry_cnt <= '0;
            end
        end else if (period_start) begin
            if (retry_cnt == RW'(RETRY_PERIODS - 1)) begin
                retrying <= 1'b0;
                retry_cnt <= '0;
            end else begin
                retry_cnt <= retry_cnt + 1'b1;
            end
        end
    end

    // Gate decisions
    always_comb begin
        next_coil = on_window && !period_start && !sn.cur_limit &&
                    !sn.loop_off && !sn.overvoltage_guard;
        // Rectifier conducts only while the node sits above the output
        next_rect = !on_window && !coil_sw_on_o && !next_coil &&
                    !sn.out_above_node && !sn.overvoltage_guard;
        if (!sn.enable || retrying) begin
            next_coil = 1'b0;
            next_rect = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            coil_sw_on_o <= 1'b0;
            rect_sw_on_o <= 1'b0;
        end else begin
            coil_sw_on_o <= next_coil;
            rect_sw_on_o <= next_rect && !next_coil;
        end
    end

    // Snubber sequencer: ramp, then conduction, then clamp
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !sn.enable) begin
            snub_st <= BSP_SN_IDLE;
        end else begin
            case (snub_st)
                BSP_SN_IDLE: begin
                    if (coil_sw_on_o) begin
                        snub_st <= BSP_SN_RAMP;
                    end
                end
                BSP_SN_RAMP: begin
                    if (rect_sw_on_o) begin
                        snub_st <= BSP_SN_CONDUCT;
                    end
                end
                BSP_SN_CONDUCT: begin
                    if (!rect_sw_on_o && !coil_sw_on_o) begin
                        snub_st <= BSP_SN_CLAMP;
                    end
                end
                BSP_SN_CLAMP: begin
                    if (period_start || next_coil) begin
                        snub_st <= BSP_SN_IDLE;
                    end
                end
                default: snub_st <= BSP_SN_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            snub_on_o <= 1'b0;
        end else begin
            snub_on_o <= (snub_st == BSP_SN_CLAMP) && sn.enable &&
                         !period_start && !next_coil && !next_rect &&
                         !rect_sw_on_o && !coil_sw_on_o;
        end
    end

    // Checks
    sequence s_low_run;
        short_circuit_guard_o ##1 retrying;
    endsequence

    property p_no_shoot;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !(coil_sw_on_o && rect_sw_on_o);
    endproperty
    a_no_shoot: assert property (p_no_shoot)
        else $error("rectifier on with inductor switch");

    property p_disable_off;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !sn.enable |=> !coil_sw_on_o && !rect_sw_on_o && !snub_on_o;
    endproperty
    a_disable_off: assert property (p_disable_off)
        else $error("switch on while disabled");

    property p_overvolt;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        sn.overvoltage_guard |=> !coil_sw_on_o && !rect_sw_on_o;
    endproperty
    a_overvolt: assert property (p_overvolt)
        else $error("switch on during over-voltage");

    property p_ilim;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        sn.cur_limit && !period_start |=> !on_window;
    endproperty
    a_ilim: assert property (p_ilim)
        else $error("on-time not ended by current limit");

    property p_rect_dir;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        rect_sw_on_o |-> !$past(sn.out_above_node);
    endproperty
    a_rect_dir: assert property (p_rect_dir)
        else $error("rectifier on with output above node");

    property p_retry_off;
        @(posedge ref_clk_i) disable iff (!rst_n_i || !sn.enable)
        s_low_run |=> !coil_sw_on_o && !rect_sw_on_o;
    endproperty
    a_retry_off: assert property (p_retry_off)
        else $error("current path on during retry");

    property p_detect;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(short_circuit_guard_o) |-> $past(low_cnt) == DW'(DETECT_PERIODS);
    endproperty
    a_detect: assert property (p_detect)
        else $error("short circuit flagged early");

    property p_snub_gap;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        snub_st == BSP_SN_RAMP |-> !snub_on_o;
    endproperty
    a_snub_gap: assert property (p_snub_gap)
        else $error("snubber on before rectifier conducted");

    property p_snub_start;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        coil_sw_on_o |-> !snub_on_o;
    endproperty
    a_snub_start: assert property (p_snub_start)
        else $error("snubber on with inductor switch");
endmodule
`default_nettype wire

// File: testbench/bsp_stage_model.sv
// Purpose: Behavioural comparators of the boost stage
// Assumes: Comparator levels change at the falling clock edge
// Notes: Loop ends on-time after 8 cycles; current limit after 2
`timescale 1ns/1ps
`default_nettype none
module bsp_stage_model
    import bsp_pkg::*;
(
    input wire logic clk_i,
    input wire logic coil_on_i,
    input wire logic en_i,
    input wire logic overvolt_i,
    input wire logic low_i,
    input wire logic cl_mode_i,
    output bsp_sense_s sense_o
);
    int on_cnt = 0;
    int off_cnt = 99;
    // Inductor on-time and discharge time
    always @(negedge clk_i) begin
        on_cnt <= coil_on_i ? on_cnt + 1 : 0;
        off_cnt <= coil_on_i ? 0 : off_cnt + int'(off_cnt < 99);
    end
    // Node sits above output for 6 cycles after the switch opens
    always_comb begin
        sense_o.enable = en_i;
        sense_o.cur_limit = cl_mode_i && on_cnt >= 2;
        sense_o.overvoltage_guard = overvolt_i;
        sense_o.out_low = low_i;
        sense_o.out_above_node = !(off_cnt >= 1 && off_cnt <= 6);
        sense_o.loop_off = on_cnt >= 8;
    end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Purpose: Self-checking bench for the boost switch control
// Assumes: Switching period shortened to 40 clocks, retry to 8 periods
// Notes: A monitor counts overlap and snubber faults all run long
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bsp_pkg::*;
;
    localparam int PER = 40;
    logic ref_clk_i, rst_n_i, en, overvolt, low, cl;
    bsp_sense_s sense;
    logic coil, rect, snub, flag, sw_clk, coil_q, sw_q, gap;
    logic s_coil, s_rect, s_snub, s_flag;
    int bad_count = 0;
    int comparisons = 0;
    int n_pulse, n_swclk, max_on, on_len, norm_on;
    int v_sr = 0;
    int v_sn = 0;
    bsp_ctrl #(.PERIOD_CYC(PER), .DETECT_PERIODS(16),
        .RETRY_PERIODS(8)) DUT (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .sense_i(sense), .coil_sw_on_o(coil),
        .rect_sw_on_o(rect), .snub_on_o(snub),
        .short_circuit_guard_o(flag), .sw_clk_o(sw_clk));
    bsp_stage_model stage (.clk_i(ref_clk_i), .coil_on_i(coil),
        .en_i(en), .overvolt_i(overvolt), .low_i(low), .cl_mode_i(cl),
        .sense_o(sense));
    // Free-running reference clock
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    // Overlap and snubber timing monitor, sampled between edges
    always @(negedge ref_clk_i) begin
        if (coil && rect) v_sr++;
        if (snub && (coil || rect || gap)) v_sn++;
        if (!rst_n_i || !en || rect) gap = 1'b0;
        else if (coil) gap = 1'b1;
    end
    task automatic check(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // Watch outputs for n cycles
    task automatic observe(input int n);
        n_pulse = 0;
        n_swclk = 0;
        max_on = 0;
        on_len = 0;
        s_coil = 1'b0;
        s_rect = 1'b0;
        s_snub = 1'b0;
        s_flag = 1'b0;
        repeat (n) begin
            @(negedge ref_clk_i);
            if (coil && !coil_q) n_pulse++;
            if (sw_clk && !sw_q) n_swclk++;
            on_len = coil ? on_len + 1 : 0;
            if (on_len > max_on) max_on = on_len;
            s_coil |= coil;
            s_rect |= rect;
            s_snub |= snub;
            s_flag |= flag;
            coil_q = coil;
            sw_q = sw_clk;
        end
    endtask
    // Disabled: nothing may switch
    task automatic t_off();
        en = 1'b0;
        observe(100);
        check("gates", {s_coil, s_rect, s_snub}, 16'h0000);
    endtask
    // Normal switching: one pulse per period, rectifier then snubber
    task automatic t_run();
        en = 1'b1;
        observe(PER);
        observe(4 * PER);
        norm_on = max_on;
        check("pulses", 16'(n_pulse), 16'h0004);
        check("swclk", 16'(n_swclk), 16'h0004);
        check("rect", s_rect, 16'h0001);
        check("snub", s_snub, 16'h0001);
        check("overlap", 16'(v_sr), 16'h0000);
        check("snubgap", 16'(v_sn), 16'h0000);
    endtask
    // Current limit ends each pulse early, no second pulse in a period
    task automatic t_cl();
        cl = 1'b1;
        observe(PER);
        observe(2 * PER);
        check("clpulses", 16'(n_pulse), 16'h0002);
        check("clshort", max_on < norm_on, 16'h0001);
        cl = 1'b0;
    endtask
    // Over-voltage holds both switches off
    task automatic t_overvolt();
        overvolt = 1'b1;
        observe(20);
        observe(4 * PER);
        check("overvolt", {s_coil, s_rect}, 16'h0000);
        overvolt = 1'b0;
        observe(PER);
    endtask
    // Low output: detect, off interval, retry, resume
    task automatic t_short();
        low = 1'b1;
        observe(14 * PER);
        check("early", s_flag, 16'h0000);
        for (int i = 0; i < 200 && flag !== 1'b1; i++)
            @(negedge ref_clk_i);
        check("flag", flag, 16'h0001);
        observe(7 * PER);
        check("hold", {s_coil, s_rect}, 16'h0000);
        observe(5 * PER);
        check("retry", s_coil, 16'h0001);
        observe(500);
        observe(250);
        check("again", s_coil, 16'h0000);
        low = 1'b0;
        observe(800);
        check("resume", s_coil, 16'h0001);
        check("noflag", s_flag, 16'h0000);
        en = 1'b0;
        observe(20);
        check("clear", {flag, snub, coil}, 16'h0000);
    endtask
    // A disable restarts the detect count from zero
    task automatic t_clear();
        low = 1'b1;
        en = 1'b1;
        observe(10 * PER);
        en = 1'b0;
        observe(20);
        en = 1'b1;
        observe(10 * PER);
        check("fresh", s_flag, 16'h0000);
        low = 1'b0;
    endtask
    task automatic finish_test();
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Watchdog: about five times the expected run of some 4200 cycles
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        bad_count++;
        finish_test();
    end
    // Reset for 20 cycles, then the scenarios in order
    initial begin
        {rst_n_i, en, overvolt, low, cl, coil_q, sw_q, gap} = 8'h00;
        repeat (20) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        t_off();
        t_run();
        t_cl();
        t_overvolt();
        t_short();
        t_clear();
        finish_test();
    end
endmodule
`default_nettype wire
